// file: rtl/wdf_pkg.sv
// constants, field layout and state type for the watchdog feed block
// assumes an 8-bit register port on the single core clock
package wdf_pkg;
   // register addresses on the register port
   localparam logic [7:0] ADDR_CONTROL = 8'hA7; // control holding register
   localparam logic [7:0] ADDR_RELOAD  = 8'hC1; // reload holding register
   localparam logic [7:0] ADDR_FEED1   = 8'hC2; // first feed port
   localparam logic [7:0] ADDR_FEED2   = 8'hC3; // second feed port
   // feed key values
   localparam logic [7:0] FEED1_KEY    = 8'hA5;
   localparam logic [7:0] FEED2_KEY    = 8'h5A;
   // control byte field positions
   localparam int PRE_MSB = 7;
   localparam int PRE_LSB = 5;
   localparam int RUN_BIT = 2;
   localparam int TOF_BIT = 1;
   localparam int CLK_BIT = 0;
   // values after reset
   localparam logic [2:0] PRE_RST    = 3'h7;
   localparam logic       RUN_RST    = 1'b1;
   localparam logic       CLK_RST    = 1'b1;
   localparam logic [7:0] RELOAD_RST = 8'hFF;
   // prescaler geometry: tap n divides by two to the (5 plus n)
   localparam int          PRESC_W    = 13;
   localparam logic [3:0]  TAP_BASE   = 4'h5;
   // feed sequence state
   typedef enum logic {WDF_IDLE, WDF_ARMED} wdf_feed_t;
endpackage

// file: rtl/wdf_watchdog.sv
// watchdog holding registers, feed sequence checker and down counter
// assumes register strobes and watchdog clock ticks synchronous to clk_i
`timescale 1ns/10ps
// Functional notes
// - software writes only reach holding registers
// - new holding values wait for valid feed
// - feed is A5 to first, 5A to second
// - reads allowed between feed writes, writes break
// - bad feed in watchdog mode resets immediately
// - control write must be followed by feed
// - timer mode copies control every cycle
// - timeout is 2^(5+tap)*(reload+1)+1 ticks
// - tap 0..7, reload 0..255 accepted
// - control byte field layout fixed
// - source select: oscillator 1, peripheral 0
// - safety lock forces source select to 1
// - run control gates counting, locked to 1
// - underflow sets flag, watchdog-mode feed or zero clears
// - reset control: tap 111, run 1, source 1
// - underflow with reset enabled asserts reset
// - safety lock allows one write each
// - timer mode underflow reloads and continues
// - timer mode ignores bad feeds
module wdf_watchdog (
   input  wire logic       clk_i,            // core clock
   input  wire logic       arst_n_i,         // async reset, active low
   input  wire logic       sfr_wr_i,         // register write strobe
   input  wire logic       sfr_rd_i,         // register read strobe
   input  wire logic [7:0] sfr_addr_i,       // register address
   input  wire logic [7:0] sfr_wdata_i,      // register write data
   input  wire logic       reset_enable_cfg_i, // watchdog mode when 1
   input  wire logic       safety_lock_cfg_i,  // safety features
   input  wire logic       tof_init_i,       // flag value after reset
   input  wire logic       osc_tick_i,       // watchdog oscillator tick
   input  wire logic       pclk_tick_i,      // peripheral clock tick
   output logic      [7:0] sfr_rdata_o,      // read data
   output logic            wdt_reset_o,      // watchdog reset pulse
   output logic            underflow_o,      // underflow event pulse
   output logic      [7:0] count_o           // live down counter
);
   // all checks below run on the core clock and pause in reset
   default clocking cb_core @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   logic [7:0]  ctl_hold;      // control holding byte, flag excluded
   logic [7:0]  reload_hold;   // reload holding byte
   logic [2:0]  live_pre;      // live prescaler tap
   logic        live_run;      // live run control
   logic        live_clk;      // live source select
   logic        timeout_flag;  // sticky underflow flag
   logic        init_done;     // flag strap captured
   logic        ctl_once;      // control written since reset
   logic        reload_once;   // reload written since reset
   logic        pend_ctl;      // control write awaits feed
   logic [12:0] presc;         // prescaler
   logic        zero_hit;      // counter expired, final tick pending
   wdf_pkg::wdf_feed_t feed_st; // feed sequence state

   logic        wd_mode;       // reset function enabled
   logic        locked;        // both safety bits set
   logic        ctl_wr;        // accepted control write
   logic        reload_wr;     // accepted reload write
   logic        feed_ok;       // feed completes this cycle
   logic        feed_bad;      // feed broken this cycle
   logic        arm;           // first key accepted
   logic        tick;          // selected watchdog clock tick
   logic        run_eff;       // effective run control
   logic        clk_eff;       // effective source select
   logic [12:0] tap_mask;      // prescaler wrap mask
   logic        presc_wrap;    // prescaler reached tap
   logic        uf;            // underflow this cycle

   assign wd_mode   = reset_enable_cfg_i;
   assign locked    = reset_enable_cfg_i & safety_lock_cfg_i;
   // lock allows one write per holding register
   assign ctl_wr    = sfr_wr_i & (sfr_addr_i == wdf_pkg::ADDR_CONTROL)
                      & ~(locked & ctl_once);
   assign reload_wr = sfr_wr_i & (sfr_addr_i == wdf_pkg::ADDR_RELOAD)
                      & ~(locked & reload_once);
   assign run_eff   = live_run | locked;
   assign clk_eff   = live_clk | locked;
   // oscillator when 1, peripheral clock when 0
   assign tick      = clk_eff ? osc_tick_i : pclk_tick_i;
   assign tap_mask  = 13'((32'h1 << (wdf_pkg::TAP_BASE + live_pre)) - 32'h1);
   assign presc_wrap = (presc & tap_mask) == tap_mask;
   assign uf        = tick & run_eff & zero_hit;

   // feed sequence decode; reads never disturb it
   always_comb begin
      feed_ok  = 1'b0;
      feed_bad = 1'b0;
      arm      = 1'b0;
      if (sfr_wr_i) begin
         if (feed_st == wdf_pkg::WDF_ARMED) begin
            // any write other than the second key breaks the feed
            if (sfr_addr_i == wdf_pkg::ADDR_FEED2 &&
                sfr_wdata_i == wdf_pkg::FEED2_KEY) begin
               feed_ok = 1'b1;
            end else begin
               feed_bad = 1'b1;
            end
         end else if (sfr_addr_i == wdf_pkg::ADDR_FEED1) begin
            arm      = sfr_wdata_i == wdf_pkg::FEED1_KEY;
            feed_bad = sfr_wdata_i != wdf_pkg::FEED1_KEY;
         end else if (sfr_addr_i == wdf_pkg::ADDR_FEED2) begin
            feed_bad = 1'b1;
         end else if (pend_ctl) begin
            feed_bad = 1'b1;
         end
      end
   end

   // feed state machine
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         feed_st <= wdf_pkg::WDF_IDLE;
      end else begin
         unique case (feed_st)
            wdf_pkg::WDF_IDLE: begin
               if (arm) begin
                  feed_st <= wdf_pkg::WDF_ARMED;
               end
            end
            wdf_pkg::WDF_ARMED: begin
               if (sfr_wr_i) begin
                  feed_st <= wdf_pkg::WDF_IDLE;
               end
            end
         endcase
      end
   end

   // pending control write in watchdog mode
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_ctl <= 1'b0;
      end else if (ctl_wr && wd_mode) begin
         pend_ctl <= 1'b1;
      end else if (sfr_wr_i) begin
         pend_ctl <= 1'b0;
      end
   end

   // holding registers and write-once tracking
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctl_hold    <= {wdf_pkg::PRE_RST, 2'h0, wdf_pkg::RUN_RST,
                         1'b0, wdf_pkg::CLK_RST};
         reload_hold <= wdf_pkg::RELOAD_RST;
         ctl_once    <= 1'b0;
         reload_once <= 1'b0;
      end else begin
         if (ctl_wr) begin
            // reserved bits and flag are not stored here
            ctl_hold <= sfr_wdata_i & 8'hE5;
            ctl_once <= 1'b1;
         end
         if (reload_wr) begin
            reload_hold <= sfr_wdata_i;
            reload_once <= 1'b1;
         end
      end
   end

   // live control register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         live_pre <= wdf_pkg::PRE_RST;
         live_run <= wdf_pkg::RUN_RST;
         live_clk <= wdf_pkg::CLK_RST;
      end else if (!wd_mode || feed_ok) begin
         // timer mode copies every cycle, watchdog mode on feed
         live_pre <= ctl_hold[wdf_pkg::PRE_MSB:wdf_pkg::PRE_LSB];
         live_run <= ctl_hold[wdf_pkg::RUN_BIT];
         live_clk <= ctl_hold[wdf_pkg::CLK_BIT];
      end
   end

   // prescaler and down counter
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         presc    <= 13'h0000;
         count_o  <= wdf_pkg::RELOAD_RST;
         zero_hit <= 1'b0;
      end else if (feed_ok) begin
         presc    <= 13'h0000;
         count_o  <= reload_hold;
         zero_hit <= 1'b0;
      end else if (tick && run_eff) begin
         if (zero_hit) begin
            // final tick of the timeout, reload and carry on
            zero_hit <= 1'b0;
            count_o  <= reload_hold;
            presc    <= 13'h0000;
         end else if (presc_wrap) begin
            presc <= 13'h0000;
            if (count_o == 8'h00) begin
               zero_hit <= 1'b1;
            end else begin
               count_o <= count_o - 8'h01;
            end
         end else begin
            presc <= presc + 13'h0001;
         end
      end
   end

   // timeout flag; hardware set wins over clears
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timeout_flag <= 1'b0;
         init_done    <= 1'b0;
      end else begin
         init_done <= 1'b1;
         if (!init_done) begin
            timeout_flag <= tof_init_i;
         end else if (uf) begin
            timeout_flag <= 1'b1;
         end else if ((feed_ok && wd_mode) ||
                      (ctl_wr && !sfr_wdata_i[wdf_pkg::TOF_BIT])) begin
            timeout_flag <= 1'b0;
         end
      end
   end

   // reset and event outputs
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wdt_reset_o <= 1'b0;
         underflow_o <= 1'b0;
      end else begin
         wdt_reset_o <= wd_mode & (feed_bad | uf);
         underflow_o <= uf;
      end
   end

   // registered read data
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            wdf_pkg::ADDR_CONTROL: begin
               sfr_rdata_o <= ctl_hold | {6'h00, timeout_flag, 1'b0};
            end
            wdf_pkg::ADDR_RELOAD: begin
               sfr_rdata_o <= reload_hold;
            end
            default: begin
               sfr_rdata_o <= 8'h00;
            end
         endcase
      end
   end

   a_bad_feed_rst: assert property (
      (feed_bad && wd_mode) |=> wdt_reset_o)
      else $error("bad feed gave no reset");
   a_timer_no_rst: assert property (
      (!wd_mode && !$past(wd_mode) && init_done) |-> !wdt_reset_o)
      else $error("reset raised in timer mode");
   a_feed_loads: assert property (
      feed_ok |=> (count_o == $past(reload_hold)) && presc == 13'h0000)
      else $error("feed did not load counter");
   a_feed_keys: assert property (
      (feed_st == wdf_pkg::WDF_ARMED && $past(feed_st) == wdf_pkg::WDF_IDLE)
      |-> $past(sfr_wr_i && sfr_addr_i == wdf_pkg::ADDR_FEED1 &&
                sfr_wdata_i == wdf_pkg::FEED1_KEY))
      else $error("feed armed without first key");
   a_uf_flag: assert property (
      (uf && init_done) |=> timeout_flag && underflow_o)
      else $error("underflow did not set flag");
   a_uf_reset: assert property (
      (uf && wd_mode) |=> wdt_reset_o)
      else $error("underflow gave no reset");
   a_lock_forces: assert property (
      (locked && osc_tick_i && !feed_ok && !zero_hit && !presc_wrap) |=>
      presc == $past(presc) + 13'h0001)
      else $error("safety lock not forcing run and source");
   a_hold_wait: assert property (
      (wd_mode && $past(wd_mode) && !$past(feed_ok)) |->
      $stable(live_pre) && $stable(live_run))
      else $error("live control changed without feed");
   a_timer_copy: assert property (
      (!wd_mode) |=>
      live_pre == $past(ctl_hold[wdf_pkg::PRE_MSB:wdf_pkg::PRE_LSB]))
      else $error("timer mode copy missing");
   a_once_lock: assert property (
      (locked && ctl_once && $past(locked)) |=> $stable(ctl_hold))
      else $error("locked control rewritten");
   a_run_stop: assert property (
      (!run_eff && !feed_ok) |=> $stable(count_o))
      else $error("counter moved while stopped");
endmodule

// file: testbench/watchdog_feed_and_control_bench.sv
// self-checking bench for the watchdog feed and control block
// assumes wdf_pkg and wdf_watchdog are compiled before this file
`timescale 1ns/10ps
module watchdog_feed_and_control_bench;
   logic       clk_i              = 1'b0; // core clock, 20 ns
   logic       arst_n_i           = 1'b0; // async reset, active low
   logic       sfr_wr_i           = 1'b0; // write strobe
   logic       sfr_rd_i           = 1'b0; // read strobe
   logic [7:0] sfr_addr_i         = 8'h00; // register address
   logic [7:0] sfr_wdata_i        = 8'h00; // write data
   logic       reset_enable_cfg_i = 1'b1; // start in watchdog mode
   logic       safety_lock_cfg_i  = 1'b0; // safety lock off at first
   logic       tof_init_i         = 1'b0; // flag clear after reset
   logic       osc_tick_i         = 1'b0; // oscillator tick
   logic       pclk_tick_i        = 1'b0; // peripheral clock tick
   logic [7:0] sfr_rdata_o;               // read data
   logic       wdt_reset_o;               // watchdog reset pulse
   logic       underflow_o;               // underflow pulse
   logic [7:0] count_o;                   // live down counter
   logic [7:0] rst_seen = 8'h00;          // reset pulses counted
   logic [7:0] uf_seen  = 8'h00;          // underflow pulses counted
   logic [7:0] r0, u0;                    // counter snapshots
   int         num_errors      = 0;       // mismatches
   int         samples_checked = 0;       // comparisons made

   wdf_watchdog i_dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_wr_i(sfr_wr_i),
      .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .reset_enable_cfg_i(reset_enable_cfg_i),
      .safety_lock_cfg_i(safety_lock_cfg_i), .tof_init_i(tof_init_i),
      .osc_tick_i(osc_tick_i), .pclk_tick_i(pclk_tick_i),
      .sfr_rdata_o(sfr_rdata_o), .wdt_reset_o(wdt_reset_o),
      .underflow_o(underflow_o), .count_o(count_o));

   // free-running core clock
   always #10 clk_i = ~clk_i;

   // count event pulses so scenarios compare deltas
   always @(posedge clk_i) begin
      if (wdt_reset_o === 1'b1) rst_seen <= rst_seen + 8'h01;
      if (underflow_o === 1'b1) uf_seen <= uf_seen + 8'h01;
   end

   // compare one byte and report a mismatch
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic close_out;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one-cycle write strobe, held until the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_wr_i    <= 1'b1;
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      @(posedge clk_i);
      sfr_wr_i    <= 1'b0;
   endtask

   // one-cycle read strobe, data checked after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      sfr_rd_i   <= 1'b1;
      sfr_addr_i <= a;
      @(posedge clk_i);
      sfr_rd_i   <= 1'b0;
      #1;
      chk(sfr_rdata_o, exp);
   endtask

   // valid two-write feed, no other register write between them
   task automatic feed;
      wr(wdf_pkg::ADDR_FEED1, wdf_pkg::FEED1_KEY);
      wr(wdf_pkg::ADDR_FEED2, wdf_pkg::FEED2_KEY);
   endtask

   // n ticks on the selected source (osc=1 oscillator, osc=0 peripheral);
   // the other source ticks every cycle, so counting it shows up at once
   task automatic tk(input int n, input logic osc);
      repeat (n) begin
         @(posedge clk_i);
         osc_tick_i  <= 1'b1;
         pclk_tick_i <= 1'b1;
         @(posedge clk_i);
         osc_tick_i  <= ~osc;
         pclk_tick_i <= osc;
      end
      @(posedge clk_i);
      osc_tick_i  <= 1'b0;
      pclk_tick_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask

   // hold reset for four cycles then release
   task automatic do_reset;
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
   endtask

   // hang guard: the tests take well under 20 us
   initial begin
      #200000;
      num_errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      close_out();
   end

   initial begin
      do_reset();
      // reset values and an unmapped read
      rd(wdf_pkg::ADDR_CONTROL, 8'hE5);
      rd(wdf_pkg::ADDR_RELOAD, 8'hFF);
      rd(8'h00, 8'h00);
      // holding writes stay invisible until the feed
      wr(wdf_pkg::ADDR_RELOAD, 8'h00);
      wr(wdf_pkg::ADDR_CONTROL, 8'h05);
      chk(count_o, 8'hFF);
      r0 = rst_seen;
      wr(wdf_pkg::ADDR_FEED1, wdf_pkg::FEED1_KEY);
      rd(wdf_pkg::ADDR_CONTROL, 8'h05);
      wr(wdf_pkg::ADDR_FEED2, wdf_pkg::FEED2_KEY);
      @(posedge clk_i);
      #1;
      chk(count_o, 8'h00);
      chk(rst_seen - r0, 8'h00);
      // tap 0, reload 0: 33 oscillator ticks, peripheral ticks ignored
      u0 = uf_seen;
      tk(32, 1'b1);
      chk(uf_seen - u0, 8'h00);
      tk(1, 1'b1);
      chk(uf_seen - u0, 8'h01);
      chk(rst_seen - r0, 8'h01);
      rd(wdf_pkg::ADDR_CONTROL, 8'h07);
      feed();
      rd(wdf_pkg::ADDR_CONTROL, 8'h05);
      // broken feed sequences in watchdog mode
      r0 = rst_seen;
      wr(wdf_pkg::ADDR_FEED1, wdf_pkg::FEED1_KEY);
      wr(wdf_pkg::ADDR_FEED2, 8'h00);
      repeat (2) @(posedge clk_i);
      chk(rst_seen - r0, 8'h01);
      wr(wdf_pkg::ADDR_FEED2, wdf_pkg::FEED2_KEY);
      repeat (2) @(posedge clk_i);
      chk(rst_seen - r0, 8'h02);
      wr(wdf_pkg::ADDR_FEED1, wdf_pkg::FEED1_KEY);
      wr(wdf_pkg::ADDR_CONTROL, 8'h05);
      repeat (2) @(posedge clk_i);
      chk(rst_seen - r0, 8'h03);
      // a feed settles the control write left pending above
      feed();
      wr(wdf_pkg::ADDR_CONTROL, 8'h05);
      wr(wdf_pkg::ADDR_RELOAD, 8'h00);
      repeat (2) @(posedge clk_i);
      chk(rst_seen - r0, 8'h04);
      // timer mode: control copied without feed, bad feeds ignored
      reset_enable_cfg_i <= 1'b0;
      wr(wdf_pkg::ADDR_RELOAD, 8'h01);
      feed();
      wr(wdf_pkg::ADDR_CONTROL, 8'h04);
      r0 = rst_seen;
      wr(wdf_pkg::ADDR_FEED2, 8'h00);
      u0 = uf_seen;
      tk(65, 1'b0);
      chk(uf_seen - u0, 8'h01);
      chk(rst_seen - r0, 8'h00);
      chk(count_o, 8'h01);
      rd(wdf_pkg::ADDR_CONTROL, 8'h06);
      wr(wdf_pkg::ADDR_CONTROL, 8'h04);
      rd(wdf_pkg::ADDR_CONTROL, 8'h04);
      // run bit cleared stops counting
      wr(wdf_pkg::ADDR_CONTROL, 8'h00);
      u0 = uf_seen;
      tk(40, 1'b0);
      chk(uf_seen - u0, 8'h00);
      // safety lock: second control write blocked, run and source forced
      reset_enable_cfg_i <= 1'b1;
      safety_lock_cfg_i  <= 1'b1;
      tof_init_i         <= 1'b1;
      do_reset();
      // flag strap taken at the first edge after release
      rd(wdf_pkg::ADDR_CONTROL, 8'hE7);
      wr(wdf_pkg::ADDR_RELOAD, 8'h00);
      wr(wdf_pkg::ADDR_CONTROL, 8'h00);
      feed();
      rd(wdf_pkg::ADDR_CONTROL, 8'h00);
      wr(wdf_pkg::ADDR_CONTROL, 8'hE0);
      feed();
      rd(wdf_pkg::ADDR_CONTROL, 8'h00);
      u0 = uf_seen;
      tk(33, 1'b1);
      chk(uf_seen - u0, 8'h01);
      close_out();
   end
endmodule
